//--- verilog/conv_regs_pkg.sv
// constants for the converter control register interface
// assumes an 8-bit special function register bus with 8-bit addresses
package conv_regs_pkg;
  localparam logic [7:0] addr_offset_trim_low = 8'hD1;
  localparam logic [7:0] addr_offset_trim_mid = 8'hD2;
  localparam logic [7:0] addr_offset_trim_high = 8'hD3;
  localparam logic [7:0] addr_gain_trim_low = 8'hD4;
  localparam logic [7:0] addr_gain_trim_mid = 8'hD5;
  localparam logic [7:0] addr_gain_trim_high = 8'hD6;
  localparam logic [7:0] addr_input_selector = 8'hD7;
  localparam logic [7:0] addr_interrupt_enable_flags = 8'hD8;
  localparam logic [7:0] addr_result_low = 8'hD9;
  localparam logic [7:0] addr_result_mid = 8'hDA;
  localparam logic [7:0] addr_result_high = 8'hDB;
  localparam logic [7:0] addr_converter_control_0 = 8'hDC;
  localparam logic [7:0] addr_converter_control_1 = 8'hDD;

  localparam logic [7:0] rst_offset_trim_byte = 8'h00;
  localparam logic [7:0] rst_gain_trim_low = 8'h5A;
  localparam logic [7:0] rst_gain_trim_mid = 8'hEC;
  localparam logic [7:0] rst_gain_trim_high = 8'h5F;
  localparam logic [7:0] rst_input_selector = 8'h01;
  localparam logic [7:0] rst_converter_control_0 = 8'h30;
  localparam logic [7:0] rst_converter_control_1 = 8'h00;
  localparam logic [23:0] rst_result = 24'h000000;

  // interrupt_enable_flags layout
  localparam int smod1_bit = 7;
  localparam int fixed_one_bit = 6;
  localparam int aux_irq_enable_bit = 5;
  localparam int aux_irq_flag_bit = 4;
  localparam int watchdog_irq_flag_bit = 3;
  localparam logic smod1_rst = 1'b0;

  // converter_control_0 / _1 layout
  localparam int burnout_current_enable_bit = 6;
  localparam int result_sign_format_bit = 6;
  // sign format, settling and calibration bits are kept; calibration reads back zero
  localparam logic [7:0] converter_control_1_mask = 8'h77;
  localparam logic [7:0] converter_control_1_read_mask = 8'h70;

  // selector codes
  localparam logic [3:0] sel_common_input = 4'h8;
  localparam logic [7:0] sel_temperature = 8'hFF;

  // calibration modes
  typedef enum logic [2:0] {
    cal_none = 3'h0,
    cal_self_both = 3'h1,
    cal_self_offset = 3'h2,
    cal_self_gain = 3'h3,
    cal_sys_offset = 3'h4,
    cal_sys_gain = 3'h5
  } cal_mode_type;
endpackage

//--- verilog/trim_word.sv
// one 24-bit correction word built from three byte registers
// assumes byte writes and calibration loads are one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module trim_word #(
  parameter logic [23:0] reset_value = 24'h000000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] byte_write_in,
  input wire logic [7:0] write_data_in,
  input wire logic load_in,
  input wire logic [23:0] load_value_in,
  output logic [23:0] word_out
);
  logic [23:0] word;
  logic [23:0] next_word;

  // a software byte write wins over a calibration load in the same cycle
  always_comb begin
    next_word = word;
    if (load_in) begin
      next_word = load_value_in;
    end
    for (int i = 0; i < 3; i++) begin
      if (byte_write_in[i]) begin
        next_word[i*8 +: 8] = write_data_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      word <= reset_value;
    end else begin
      word <= next_word;
    end
  end

  assign word_out = word;

  byte_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_write_in[0] |=> word[7:0] == $past(write_data_in))
    else $error("trim low byte write lost");
  load_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    load_in && byte_write_in == 3'b000 |=> word == $past(load_value_in))
    else $error("calibration value not loaded");
endmodule
`default_nettype wire

//--- verilog/conv_regs.sv
// register interface of the delta-sigma converter on the sfr bus
// assumes single-cycle sfr strobes; reads answer combinationally on sfr_rdata_out
// How it works
// - offset word bytes writable, applied at once
// - gain word writable, resets 5F EC 5A
// - upper selector nibble picks positive input
// - lower nibble negative input, reset 01h
// - temperature sensor only when selector is FFh
// - 24-bit read-only result, cleared at reset
// - low result read clears converter interrupt
// - aux enable bit 5 gates shared interrupt
// - aux flag sets on event, software clears
// - writing aux flag one raises aux interrupt
// - watchdog flag sticky, software write raises it
// - watchdog interrupt only when reset disabled
// - burnout bit 6 drives current sources, off
// - writing calibration field starts calibration
// - sign bit picks bipolar or unipolar result
`timescale 1ns/10ps
`default_nettype none
module conv_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  input wire logic result_valid_in,
  input wire logic [23:0] result_in,
  input wire logic cal_done_in,
  input wire logic [23:0] cal_offset_in,
  input wire logic [23:0] cal_gain_in,
  input wire logic aux_event_in,
  input wire logic watchdog_event_in,
  input wire logic watchdog_reset_enable_in,
  output logic [23:0] offset_trim_out,
  output logic [23:0] gain_trim_out,
  output logic [3:0] positive_channel_sel_out,
  output logic [3:0] negative_channel_sel_out,
  output logic temp_sensor_sel_out,
  output logic burnout_current_enable_out,
  output logic [7:0] converter_control_0_out,
  output logic result_sign_format_out,
  output logic [2:0] cal_start_mode_out,
  output logic cal_start_out,
  output logic conv_irq_out,
  output logic aux_irq_out,
  output logic watchdog_irq_out,
  output logic smod1_out
);
  logic wr_ok;
  logic rd_ok;
  logic [2:0] offset_bw;
  logic [2:0] gain_bw;
  logic offset_load;
  logic gain_load;
  logic [7:0] input_selector;
  logic [7:0] next_input_selector;
  logic [7:0] converter_control_0;
  logic [7:0] next_converter_control_0;
  logic [7:0] converter_control_1;
  logic [7:0] next_converter_control_1;
  logic smod1;
  logic next_smod1;
  logic aux_irq_enable;
  logic next_aux_irq_enable;
  logic aux_irq_flag;
  logic next_aux_irq_flag;
  logic watchdog_irq_flag;
  logic next_watchdog_irq_flag;
  logic [23:0] result;
  logic [23:0] next_result;
  logic conv_pending;
  logic next_conv_pending;
  conv_regs_pkg::cal_mode_type cal_active;
  conv_regs_pkg::cal_mode_type next_cal_active;

  assign wr_ok = sfr_wr_in;
  assign rd_ok = sfr_rd_in && !sfr_wr_in;

  // calibration kinds that touch each word
  assign offset_load = cal_done_in && (cal_active == conv_regs_pkg::cal_self_both
    || cal_active == conv_regs_pkg::cal_self_offset || cal_active == conv_regs_pkg::cal_sys_offset);
  assign gain_load = cal_done_in && (cal_active == conv_regs_pkg::cal_self_both
    || cal_active == conv_regs_pkg::cal_self_gain || cal_active == conv_regs_pkg::cal_sys_gain);

  always_comb begin
    offset_bw[0] = wr_ok && sfr_addr_in == conv_regs_pkg::addr_offset_trim_low;
    offset_bw[1] = wr_ok && sfr_addr_in == conv_regs_pkg::addr_offset_trim_mid;
    offset_bw[2] = wr_ok && sfr_addr_in == conv_regs_pkg::addr_offset_trim_high;
    gain_bw[0] = wr_ok && sfr_addr_in == conv_regs_pkg::addr_gain_trim_low;
    gain_bw[1] = wr_ok && sfr_addr_in == conv_regs_pkg::addr_gain_trim_mid;
    gain_bw[2] = wr_ok && sfr_addr_in == conv_regs_pkg::addr_gain_trim_high;
  end

  trim_word #(
    .reset_value({3{conv_regs_pkg::rst_offset_trim_byte}})
  ) offset_word (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .byte_write_in(offset_bw),
    .write_data_in(sfr_wdata_in),
    .load_in(offset_load),
    .load_value_in(cal_offset_in),
    .word_out(offset_trim_out)
  );

  trim_word #(
    .reset_value({conv_regs_pkg::rst_gain_trim_high, conv_regs_pkg::rst_gain_trim_mid,
                  conv_regs_pkg::rst_gain_trim_low})
  ) gain_word (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .byte_write_in(gain_bw),
    .write_data_in(sfr_wdata_in),
    .load_in(gain_load),
    .load_value_in(cal_gain_in),
    .word_out(gain_trim_out)
  );

  // control registers
  always_comb begin
    next_input_selector = input_selector;
    next_converter_control_0 = converter_control_0;
    next_converter_control_1 = converter_control_1;
    next_smod1 = smod1;
    next_aux_irq_enable = aux_irq_enable;
    next_cal_active = cal_active;
    if (cal_done_in) begin
      next_cal_active = conv_regs_pkg::cal_none;
    end
    if (wr_ok) begin
      case (sfr_addr_in)
        conv_regs_pkg::addr_input_selector: begin
          next_input_selector = sfr_wdata_in;
        end
        conv_regs_pkg::addr_converter_control_0: begin
          next_converter_control_0 = sfr_wdata_in & 8'h7F;
        end
        conv_regs_pkg::addr_converter_control_1: begin
          next_converter_control_1 = sfr_wdata_in & conv_regs_pkg::converter_control_1_mask;
          // reserved codes leave cal_active unchanged; cal_start_out still pulses
          if (sfr_wdata_in[2:0] <= 3'h5) begin
            next_cal_active = conv_regs_pkg::cal_mode_type'(sfr_wdata_in[2:0]);
          end
        end
        conv_regs_pkg::addr_interrupt_enable_flags: begin
          next_smod1 = sfr_wdata_in[conv_regs_pkg::smod1_bit];
          next_aux_irq_enable = sfr_wdata_in[conv_regs_pkg::aux_irq_enable_bit];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      input_selector <= conv_regs_pkg::rst_input_selector;
      converter_control_0 <= conv_regs_pkg::rst_converter_control_0;
      converter_control_1 <= conv_regs_pkg::rst_converter_control_1;
      smod1 <= conv_regs_pkg::smod1_rst;
      aux_irq_enable <= 1'b0;
      cal_active <= conv_regs_pkg::cal_none;
    end else begin
      input_selector <= next_input_selector;
      converter_control_0 <= next_converter_control_0;
      converter_control_1 <= next_converter_control_1;
      smod1 <= next_smod1;
      aux_irq_enable <= next_aux_irq_enable;
      cal_active <= next_cal_active;
    end
  end

  // flags, result and converter interrupt; hardware set wins over clear
  always_comb begin
    next_aux_irq_flag = aux_irq_flag;
    next_watchdog_irq_flag = watchdog_irq_flag;
    next_result = result;
    next_conv_pending = conv_pending;
    if (wr_ok && sfr_addr_in == conv_regs_pkg::addr_interrupt_enable_flags) begin
      next_aux_irq_flag = sfr_wdata_in[conv_regs_pkg::aux_irq_flag_bit];
      next_watchdog_irq_flag = sfr_wdata_in[conv_regs_pkg::watchdog_irq_flag_bit];
    end
    if (rd_ok && sfr_addr_in == conv_regs_pkg::addr_result_low) begin
      next_conv_pending = 1'b0;
    end
    if (result_valid_in) begin
      next_result = result_in;
      next_conv_pending = 1'b1;
      next_aux_irq_flag = 1'b1;
    end
    if (aux_event_in) begin
      next_aux_irq_flag = 1'b1;
    end
    if (watchdog_event_in && !watchdog_reset_enable_in) begin
      next_watchdog_irq_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aux_irq_flag <= 1'b0;
      watchdog_irq_flag <= 1'b0;
      result <= conv_regs_pkg::rst_result;
      conv_pending <= 1'b0;
    end else begin
      aux_irq_flag <= next_aux_irq_flag;
      watchdog_irq_flag <= next_watchdog_irq_flag;
      result <= next_result;
      conv_pending <= next_conv_pending;
    end
  end

  // read mux; bit 6 of the flag register always reads one
  always_comb begin
    sfr_hit_out = 1'b1;
    sfr_rdata_out = 8'h00;
    case (sfr_addr_in)
      conv_regs_pkg::addr_offset_trim_low: sfr_rdata_out = offset_trim_out[7:0];
      conv_regs_pkg::addr_offset_trim_mid: sfr_rdata_out = offset_trim_out[15:8];
      conv_regs_pkg::addr_offset_trim_high: sfr_rdata_out = offset_trim_out[23:16];
      conv_regs_pkg::addr_gain_trim_low: sfr_rdata_out = gain_trim_out[7:0];
      conv_regs_pkg::addr_gain_trim_mid: sfr_rdata_out = gain_trim_out[15:8];
      conv_regs_pkg::addr_gain_trim_high: sfr_rdata_out = gain_trim_out[23:16];
      conv_regs_pkg::addr_input_selector: sfr_rdata_out = input_selector;
      conv_regs_pkg::addr_interrupt_enable_flags: begin
        sfr_rdata_out = {smod1, 1'b1, aux_irq_enable, aux_irq_flag, watchdog_irq_flag, 3'h0};
      end
      conv_regs_pkg::addr_result_low: sfr_rdata_out = result[7:0];
      conv_regs_pkg::addr_result_mid: sfr_rdata_out = result[15:8];
      conv_regs_pkg::addr_result_high: sfr_rdata_out = result[23:16];
      conv_regs_pkg::addr_converter_control_0: sfr_rdata_out = converter_control_0;
      // calibration field reads back as zero
      conv_regs_pkg::addr_converter_control_1: begin
        sfr_rdata_out = converter_control_1 & conv_regs_pkg::converter_control_1_read_mask;
      end
      default: sfr_hit_out = 1'b0;
    endcase
  end

  assign temp_sensor_sel_out = input_selector == conv_regs_pkg::sel_temperature;
  assign positive_channel_sel_out = input_selector[7:4];
  assign negative_channel_sel_out = input_selector[3:0];
  assign burnout_current_enable_out = converter_control_0[conv_regs_pkg::burnout_current_enable_bit];
  assign converter_control_0_out = converter_control_0;
  assign result_sign_format_out = converter_control_1[conv_regs_pkg::result_sign_format_bit];
  assign cal_start_out = wr_ok && sfr_addr_in == conv_regs_pkg::addr_converter_control_1;
  assign cal_start_mode_out = sfr_wdata_in[2:0];
  assign conv_irq_out = conv_pending;
  assign aux_irq_out = aux_irq_enable && aux_irq_flag;
  assign watchdog_irq_out = watchdog_irq_flag && !watchdog_reset_enable_in;
  assign smod1_out = smod1;

  low_read_clears_a: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_ok && sfr_addr_in == conv_regs_pkg::addr_result_low && !result_valid_in |=> !conv_pending)
    else $error("converter interrupt not cleared by low read");
  low_read_keeps_aux_a: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_ok && aux_irq_flag && !wr_ok |=> aux_irq_flag)
    else $error("aux flag dropped by a read");
  aux_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in)
    aux_event_in |=> aux_irq_flag)
    else $error("aux event lost");
  aux_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    aux_irq_out |-> aux_irq_enable && aux_irq_flag)
    else $error("aux interrupt without enable");
  aux_sw_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_ok && sfr_addr_in == conv_regs_pkg::addr_interrupt_enable_flags && sfr_wdata_in == 8'h30
    |=> aux_irq_out)
    else $error("software set did not raise aux interrupt");
  wdt_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    watchdog_irq_flag && !wr_ok |=> watchdog_irq_flag)
    else $error("watchdog flag cleared without software");
  wdt_reset_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
    watchdog_reset_enable_in |-> !watchdog_irq_out)
    else $error("watchdog interrupt while reset action on");
  temp_sel_a: assert property (@(posedge clk_in) disable iff (rst_in)
    temp_sensor_sel_out |-> positive_channel_sel_out == 4'hF && negative_channel_sel_out == 4'hF)
    else $error("temperature sensor routed with wrong selector");
  result_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
    result_valid_in |=> result == $past(result_in) && conv_pending)
    else $error("result not captured");
  cal_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cal_start_out && sfr_wdata_in[2:0] == 3'h2 && !cal_done_in |=> cal_active == conv_regs_pkg::cal_self_offset)
    else $error("calibration not started");
  sel_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_ok && sfr_addr_in == conv_regs_pkg::addr_input_selector
    |=> {positive_channel_sel_out, negative_channel_sel_out} == $past(sfr_wdata_in))
    else $error("input selector write lost");
  burnout_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_ok && sfr_addr_in == conv_regs_pkg::addr_converter_control_0
    |=> burnout_current_enable_out == $past(sfr_wdata_in[conv_regs_pkg::burnout_current_enable_bit]))
    else $error("burnout control write lost");
  sign_format_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_ok && sfr_addr_in == conv_regs_pkg::addr_converter_control_1
    |=> result_sign_format_out == $past(sfr_wdata_in[conv_regs_pkg::result_sign_format_bit]))
    else $error("sign format write lost");

  cal_cover_c: cover property (@(posedge clk_in) disable iff (rst_in) offset_load ##1 gain_load);
  temp_cover_c: cover property (@(posedge clk_in) disable iff (rst_in) temp_sensor_sel_out);
  clear_cover_c: cover property (@(posedge clk_in) disable iff (rst_in)
    conv_pending ##1 !conv_pending);
  aux_raise_cover_c: cover property (@(posedge clk_in) disable iff (rst_in) aux_irq_out);
endmodule
`default_nettype wire

//--- verification/sfr_core_model.sv
// processor core side of the special function register bus
// assumes a free running clk_in; one strobe per transfer, idle cycle between
`timescale 1ns/10ps
`default_nettype none
module sfr_core_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // released lines show the inverse so stale values never pass for good data
  task automatic release_bus();
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    release_bus();
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    d = rdata_in;
    release_bus();
  endtask
endmodule
`default_nettype wire

//--- verification/conv_regs_tb_top.sv
// self-checking bench for conv_regs, one task per scenario
// assumes conv_regs_pkg and sfr_core_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module conv_regs_tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr, wdata, rdata, ctl0;
  logic wr, rd, hit, temp_sel, burnout, sign_fmt, cal_start, conv_irq, aux_irq, wd_irq, smod1;
  logic res_valid = 1'b0, cal_done = 1'b0, aux_ev = 1'b0, wd_ev = 1'b0, wd_rst_en = 1'b0;
  logic [23:0] res = 24'h000000, cal_off = 24'h000000, cal_gain = 24'h000000, off_w, gain_w;
  logic [3:0] pos_sel, neg_sel;
  logic [2:0] cal_mode;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 clk_in = ~clk_in;
  sfr_core_model core (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
    .rdata_in(rdata));
  conv_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .sfr_hit_out(hit), .result_valid_in(res_valid),
    .result_in(res), .cal_done_in(cal_done), .cal_offset_in(cal_off), .cal_gain_in(cal_gain),
    .aux_event_in(aux_ev), .watchdog_event_in(wd_ev), .watchdog_reset_enable_in(wd_rst_en),
    .offset_trim_out(off_w), .gain_trim_out(gain_w), .positive_channel_sel_out(pos_sel),
    .negative_channel_sel_out(neg_sel), .temp_sensor_sel_out(temp_sel), .burnout_current_enable_out(burnout),
    .converter_control_0_out(ctl0), .result_sign_format_out(sign_fmt), .cal_start_mode_out(cal_mode),
    .cal_start_out(cal_start), .conv_irq_out(conv_irq), .aux_irq_out(aux_irq), .watchdog_irq_out(wd_irq),
    .smod1_out(smod1));
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    core.sfr_read(a, v);
    check({16'h0000, v}, {16'h0000, exp}, $sformatf("read of %h", a));
  endtask
  task automatic t_reset();
    logic [7:0] exp [12] = '{8'h00, 8'h00, 8'h00, 8'h5A, 8'hEC, 8'h5F, 8'h01, 8'h40, 8'h00, 8'h00, 8'h00, 8'h30};
    for (int i = 0; i < 12; i++) rd_chk(8'hD1 + 8'(i), exp[i]);
    check(gain_w, 24'h5FEC5A, "gain word at reset");
    check({18'h0, smod1, aux_irq, wd_irq, conv_irq, burnout, temp_sel}, 24'h0, "flags at reset");
    fork
      core.sfr_write(8'hE0, 8'hFF);
      begin
        @(negedge clk_in);
        #1 check({23'h0, hit}, 24'h0, "unmapped address claimed");
      end
    join
    check({15'h0, pos_sel, neg_sel, temp_sel}, {15'h0, 8'h01, 1'b0}, "selector after unmapped write");
    $display("test reset done");
  endtask
  task automatic t_trim();
    for (int i = 0; i < 3; i++) begin
      core.sfr_write(8'hD1 + 8'(i), 8'h11 * 8'(i + 1));
      core.sfr_write(8'hD4 + 8'(i), 8'hA0 + 8'(i));
    end
    check(off_w, 24'h332211, "offset word");
    check(gain_w, 24'hA2A1A0, "gain word");
    rd_chk(8'hD2, 8'h22);
    rd_chk(8'hD6, 8'hA2);
    $display("test trim done");
  endtask
  task automatic t_sel();
    for (int p = 0; p < 9; p++) begin
      core.sfr_write(8'hD7, {4'(p), 4'(8 - p)});
      check({15'h0, pos_sel, neg_sel, temp_sel}, {15'h0, 4'(p), 4'(8 - p), 1'b0}, "channel select");
    end
    core.sfr_write(8'hD7, 8'hFF);
    check({23'h0, temp_sel}, 24'h1, "temperature select");
    core.sfr_write(8'hD7, 8'hF8);
    check({23'h0, temp_sel}, 24'h0, "temperature needs both nibbles");
    $display("test selector done");
  endtask
  task automatic t_result();
    @(negedge clk_in);
    res = 24'hC3A51E;
    res_valid = 1'b1;
    @(negedge clk_in);
    res_valid = 1'b0;
    res = ~res;
    check({23'h0, conv_irq}, 24'h1, "converter irq raised");
    core.sfr_write(8'hD9, 8'hFF);
    rd_chk(8'hDB, 8'hC3);
    rd_chk(8'hDA, 8'hA5);
    check({23'h0, conv_irq}, 24'h1, "irq kept by upper reads");
    rd_chk(8'hD9, 8'h1E);
    check({23'h0, conv_irq}, 24'h0, "irq cleared by low read");
    rd_chk(8'hD8, 8'h50);
    core.sfr_write(8'hD8, 8'h00);
    rd_chk(8'hD8, 8'h40);
    $display("test result done");
  endtask
  task automatic t_aux();
    core.sfr_write(8'hD8, 8'h90);
    check({22'h0, smod1, aux_irq}, {22'h0, 2'b10}, "aux masked");
    core.sfr_write(8'hD8, 8'h30);
    check({23'h0, aux_irq}, 24'h1, "aux raised by software");
    core.sfr_write(8'hD8, 8'h20);
    check({23'h0, aux_irq}, 24'h0, "aux cleared");
    @(negedge clk_in);
    aux_ev = 1'b1;
    @(negedge clk_in);
    aux_ev = 1'b0;
    check({23'h0, aux_irq}, 24'h1, "aux raised by event");
    rd_chk(8'hD8, 8'h70);
    core.sfr_write(8'hD8, 8'h00);
    $display("test aux done");
  endtask
  task automatic t_wd();
    core.sfr_write(8'hD8, 8'h08);
    repeat (5) @(posedge clk_in);
    #1 check({23'h0, wd_irq}, 24'h1, "watchdog flag sticky");
    core.sfr_write(8'hD8, 8'h00);
    check({23'h0, wd_irq}, 24'h0, "watchdog cleared");
    @(negedge clk_in);
    wd_ev = 1'b1;
    @(negedge clk_in);
    wd_ev = 1'b0;
    check({23'h0, wd_irq}, 24'h1, "watchdog event");
    @(negedge clk_in);
    wd_rst_en = 1'b1;
    #1 check({23'h0, wd_irq}, 24'h0, "watchdog irq in reset mode");
    core.sfr_write(8'hD8, 8'h00);
    @(negedge clk_in);
    wd_ev = 1'b1;
    @(negedge clk_in);
    wd_ev = 1'b0;
    wd_rst_en = 1'b0;
    #1 check({23'h0, wd_irq}, 24'h0, "watchdog event in reset mode");
    $display("test watchdog done");
  endtask
  task automatic t_ctl();
    core.sfr_write(8'hDC, 8'h70);
    check({15'h0, burnout, ctl0}, 24'h000170, "burnout on");
    core.sfr_write(8'hDC, 8'h30);
    check({23'h0, burnout}, 24'h0, "burnout off");
    // the start strobe lives only in the write cycle, so sample it there
    for (int c = 1; c < 6; c++) begin
      fork
        core.sfr_write(8'hDD, {5'b01000, 3'(c)});
        begin
          @(negedge clk_in);
          #1 check({19'h0, hit, cal_start, cal_mode}, {19'h0, 2'b11, 3'(c)}, "calibration start");
        end
      join
    end
    check({23'h0, sign_fmt}, 24'h1, "unipolar format");
    rd_chk(8'hDD, 8'h40);
    core.sfr_write(8'hDD, 8'h01);
    check({23'h0, sign_fmt}, 24'h0, "bipolar format");
    @(negedge clk_in);
    cal_off = 24'h123456;
    cal_gain = 24'h654321;
    cal_done = 1'b1;
    @(negedge clk_in);
    cal_done = 1'b0;
    cal_off = ~cal_off;
    cal_gain = ~cal_gain;
    check(off_w, 24'h123456, "offset loaded");
    check(gain_w, 24'h654321, "gain loaded");
    rd_chk(8'hD3, 8'h12);
    $display("test control done");
  endtask
  task automatic t_rerun();
    @(negedge clk_in);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    check(off_w, 24'h000000, "offset after second reset");
    check(gain_w, 24'h5FEC5A, "gain after second reset");
    rd_chk(8'hD7, 8'h01);
    rd_chk(8'hDD, 8'h00);
    $display("test second reset done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("Error %0t: run took too long", $time);
      results();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    t_reset();
    t_trim();
    t_sel();
    t_result();
    t_aux();
    t_wd();
    t_ctl();
    t_rerun();
    results();
  end
endmodule
`default_nettype wire
